// ==== src/tbops_defs.svh ====
`ifndef TBOPS_DEFS_SVH
`define TBOPS_DEFS_SVH
`define TBOPS_REG_ADDR 5'h12
`define TBOPS_BIT_RJAB 15
`define TBOPS_BIT_POL 14
`define TBOPS_BIT_JABINH 5
`define TBOPS_BIT_RSV1 4
`define TBOPS_BIT_APINH 3
`define TBOPS_BIT_SQEINH 2
`define TBOPS_BIT_LLINH 1
`define TBOPS_BIT_SQINH 0
`define TBOPS_CTRL_RESET 6'h10
`define TBOPS_CTRL_MASK 16'h003F
`define TBOPS_CTRL_W 6
`define TBOPS_SQE_W 16
`define TBOPS_NFLAG 2
`define TBOPS_FLAG_RJAB 1
`define TBOPS_FLAG_POL 0
`define TBOPS_JAB_NS 20000000
`define TBOPS_SQE_NS 1000
`define TBOPS_CLK_NS 25
`define TBOPS_JAB_CYC (`TBOPS_JAB_NS / `TBOPS_CLK_NS)
`define TBOPS_SQE_CYC ((`TBOPS_SQE_NS + `TBOPS_CLK_NS - 1) / `TBOPS_CLK_NS)
`endif

// ==== src/tbops_pkg.sv ====
`default_nettype none
package tbops_pkg;
    typedef logic [15:0] tbops_word_t;
    typedef enum logic [1:0] {
        TBOPS_LINK_FAIL = 2'b00,
        TBOPS_LINK_DATA = 2'b01,
        TBOPS_LINK_PASS = 2'b10
    } tbops_link_e;
endpackage
`default_nettype wire

// ==== src/tbops_jab_if.sv ====
`default_nettype none
interface tbops_jab_if;
    logic active;
    logic inhibit;
    logic jabber;
    modport ctl (output active, output inhibit, input jabber);
    modport mon (input active, input inhibit, output jabber);
endinterface
`default_nettype wire

// ==== src/tbops_jab_mon.sv ====
`include "tbops_defs.svh"
`default_nettype none
// jabber timer, instanced once for the transmit and once for the receive path
module tbops_jab_mon #(
    parameter int unsigned LIMIT = `TBOPS_JAB_CYC
) (
    input wire logic ref_clk, // clock
    input wire logic rstn, // async reset
    input wire logic clk_en, // freezes state
    tbops_jab_if.mon jif // activity in, jabber out
);
    logic [31:0] cnt_q, cnt_d;
    logic jab_q, jab_d;
    always_comb begin
        cnt_d = cnt_q;
        jab_d = jab_q;
        if (!jif.active || jif.inhibit) begin
            cnt_d = 32'h0;
            jab_d = 1'b0;
        end else if (cnt_q >= LIMIT - 1) begin
            jab_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 32'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 32'h0;
            jab_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            jab_q <= jab_d;
        end
    end
    assign jif.jabber = jab_q;
endmodule
`default_nettype wire

// ==== src/tbops_reg.sv ====
// Function
// - remote jabber flag bit 15 latches high on receive jabber, clears on read.
// - receive jabber uses the transmit jabber criteria and only sets the flag.
// - polarity flag bit 14 latches high when the receive pair is reversed.
// - operation continues normally regardless of a pair reversal.
// - bit 5 low enables transmit jabber checking, high disables it.
// - bit 3 low auto-corrects a reversed pair, high inhibits it.
// - the polarity correction inhibit also applies at 100 megabit speed.
// - bit 2 low enables SQE test generation, high disables it.
// - the SQE test pulses collision briefly after transmit enable falls.
// - SQE test is suppressed in full duplex and repeater operation.
// - the SQE inhibit bit keeps the written value despite suppression.
// - bit 1 high holds the link integrity machine in link passed.
// - bit 0 low needs valid data for link, high needs data then idle.
`include "tbops_defs.svh"
`default_nettype none
module tbops_reg #(
    parameter int unsigned JAB_LIMIT = `TBOPS_JAB_CYC,
    parameter int unsigned SQE_LEN = `TBOPS_SQE_CYC
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic [4:0] reg_addr, // management register address
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire tbops_pkg::tbops_word_t reg_wdata, // write data
    output tbops_pkg::tbops_word_t reg_rdata, // read data, valid after rd
    input wire logic tx_en, // transmit enable
    input wire logic rx_active, // receive activity
    input wire logic rx_pol_rev, // receive pair seen reversed
    input wire logic rx_valid_data, // valid 10Base-T data seen
    input wire logic rx_idle, // idle seen after data
    input wire logic rx_link_lost, // link test fails
    input wire logic full_duplex, // full duplex mode
    input wire logic repeater, // repeater mode
    output logic col, // collision / SQE output
    output logic tx_jabber, // transmit jabber active
    output logic pol_correct, // invert receive pair
    output logic link_ok // link integrity passed
);
    import tbops_pkg::*;

    localparam int unsigned SQW = `TBOPS_SQE_W;
    localparam int unsigned CW = `TBOPS_CTRL_W;
    localparam int unsigned NF = `TBOPS_NFLAG;

    // control field: only the six low bits 5:0, reserved bit 4 included, hold state
    logic [CW-1:0] ctrl_q, ctrl_d;
    tbops_word_t rdata_q, rdata_d;
    logic hit_rd, hit_wr;

    // latching status flags, one slot per flag
    logic [NF-1:0] flag_ev;
    wire logic [NF-1:0] flag_vec;

    // sqe, polarity and transmit history
    logic tx_en_q, tx_en_d;
    logic [SQW-1:0] sqe_q, sqe_d;
    logic sqe_start;
    logic col_q, col_d;
    logic txjab_q, txjab_d;
    logic polc_q, polc_d;

    // link integrity
    tbops_link_e lnk_q, lnk_d;
    logic link_q, link_d;

    tbops_jab_if txj ();
    tbops_jab_if rxj ();

    tbops_jab_mon #(
        .LIMIT(JAB_LIMIT)
    ) u_txjab (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .jif(txj)
    );

    // same timer module and limit as transmit, so both paths share one jabber criterion
    tbops_jab_mon #(
        .LIMIT(JAB_LIMIT)
    ) u_rxjab (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .jif(rxj)
    );

    assign txj.active = tx_en;
    assign txj.inhibit = ctrl_q[`TBOPS_BIT_JABINH];
    // receive jabber is informational: the inhibit bit does not reach it
    assign rxj.active = rx_active;
    assign rxj.inhibit = 1'b0;

    assign hit_rd = reg_rd && (reg_addr == `TBOPS_REG_ADDR);
    assign hit_wr = reg_wr && (reg_addr == `TBOPS_REG_ADDR);

    // reserved bits 13:6 are not stored but reserved bit 4 is; software keeps bit 4 at its default
    always_comb begin
        ctrl_d = ctrl_q;
        if (hit_wr) begin
            ctrl_d = reg_wdata[CW-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `TBOPS_CTRL_RESET;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
        end
    end

    assign flag_ev[`TBOPS_FLAG_RJAB] = rxj.jabber;
    assign flag_ev[`TBOPS_FLAG_POL] = rx_pol_rev;

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_flag
            logic fl_q, fl_d;
            always_comb begin
                fl_d = fl_q;
                if (hit_rd) begin
                    fl_d = 1'b0;
                end
                // an event in the read cycle wins, so the next read sees it
                if (flag_ev[gi]) begin
                    fl_d = 1'b1;
                end
            end
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    fl_q <= 1'b0;
                end else if (clk_en) begin
                    fl_q <= fl_d;
                end
            end
            assign flag_vec[gi] = fl_q;
        end
    endgenerate

    // the read word is captured, so reg_rdata stays put between reads
    always_comb begin
        rdata_d = rdata_q;
        if (hit_rd) begin
            rdata_d = '0;
            rdata_d[`TBOPS_BIT_RJAB] = flag_vec[`TBOPS_FLAG_RJAB];
            rdata_d[`TBOPS_BIT_POL] = flag_vec[`TBOPS_FLAG_POL];
            rdata_d[CW-1:0] = ctrl_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // suppression in full duplex or repeater never rewrites ctrl_q
    assign sqe_start = tx_en_q && !tx_en
        && !ctrl_q[`TBOPS_BIT_SQEINH]
        && !full_duplex && !repeater;

    always_comb begin
        tx_en_d = tx_en;
        sqe_d = sqe_q;
        if (sqe_start) begin
            sqe_d = SQW'(SQE_LEN);
        end else if (sqe_q != '0) begin
            sqe_d = sqe_q - SQW'(1);
        end
        col_d = (sqe_d != '0);
        txjab_d = txj.jabber;
        // one control serves both speeds, so no speed input is consulted;
        // a reversal only steers the correction, traffic never stops
        polc_d = rx_pol_rev && !ctrl_q[`TBOPS_BIT_APINH];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_en_q <= 1'b0;
            sqe_q <= '0;
            col_q <= 1'b0;
            txjab_q <= 1'b0;
            polc_q <= 1'b0;
        end else if (clk_en) begin
            tx_en_q <= tx_en_d;
            sqe_q <= sqe_d;
            col_q <= col_d;
            txjab_q <= txjab_d;
            polc_q <= polc_d;
        end
    end

    assign col = col_q;
    assign tx_jabber = txjab_q;
    assign pol_correct = polc_q;

    always_comb begin
        lnk_d = lnk_q;
        unique case (lnk_q)
            TBOPS_LINK_FAIL: begin
                if (rx_valid_data) begin
                    if (ctrl_q[`TBOPS_BIT_SQINH]) begin
                        lnk_d = TBOPS_LINK_DATA;
                    end else begin
                        lnk_d = TBOPS_LINK_PASS;
                    end
                end
            end
            TBOPS_LINK_DATA: begin
                if (rx_idle) begin
                    lnk_d = TBOPS_LINK_PASS;
                end
            end
            TBOPS_LINK_PASS: begin
                if (rx_link_lost) begin
                    lnk_d = TBOPS_LINK_FAIL;
                end
            end
            default: begin
                lnk_d = TBOPS_LINK_FAIL;
            end
        endcase
        // the forced pass overrides whatever the receiver reports
        if (ctrl_q[`TBOPS_BIT_LLINH]) begin
            lnk_d = TBOPS_LINK_PASS;
        end
        link_d = (lnk_d == TBOPS_LINK_PASS);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lnk_q <= TBOPS_LINK_FAIL;
            link_q <= 1'b0;
        end else if (clk_en) begin
            lnk_q <= lnk_d;
            link_q <= link_d;
        end
    end

    assign link_ok = link_q;
endmodule
`default_nettype wire

// ==== test/tbops_reg_sva.sv ====
`default_nettype none
module tbops_reg_sva (
    input wire logic ref_clk, // clock
    input wire logic rstn, // reset
    input wire logic clk_en, // enable
    input wire logic [4:0] reg_addr, // address
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire tbops_pkg::tbops_word_t reg_wdata, // write data
    input wire tbops_pkg::tbops_word_t reg_rdata, // read data
    input wire logic tx_en, // transmit
    input wire logic rx_pol_rev, // reversed
    input wire logic rx_link_lost, // link lost
    input wire logic full_duplex, // duplex
    input wire logic repeater, // repeater
    input wire logic col, // collision
    input wire logic tx_jabber, // jabber
    input wire logic pol_correct, // polarity fix
    input wire logic link_ok // link
);
    import tbops_pkg::*;
    logic acc;
    logic [5:0] ctrl_q;
    logic [5:0] ctrl_d;
    assign acc = clk_en && reg_addr == 5'h12;
    always_comb begin
        ctrl_d = acc && reg_wr ? reg_wdata[5:0] : ctrl_q;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 6'h10;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_ctrl_back: assert property (
        acc && reg_rd && !reg_wr |=> reg_rdata[13:0] == {8'h00, $past(ctrl_q)})
        else $error("control readback wrong");
    a_pol_fix: assert property (
        clk_en |=> pol_correct == $past(rx_pol_rev && !ctrl_q[3]))
        else $error("polarity correction wrong");
    a_sqe_pulse: assert property (
        $fell(tx_en) && clk_en && !ctrl_q[2] && !full_duplex && !repeater
        |=> col) else $error("no sqe pulse");
    a_sqe_gate: assert property (
        $rose(col) |-> $past(!full_duplex && !repeater && !ctrl_q[2]))
        else $error("sqe pulse not allowed");
    a_link_force: assert property (
        ctrl_q[1] && clk_en |-> ##[1:2] link_ok) else $error("link not forced");
    a_link_drop: assert property (
        (!ctrl_q[1] && rx_link_lost && clk_en)[*3] |-> !link_ok)
        else $error("link kept after loss");
    a_flag_keep: assert property (
        (acc && reg_rd && rx_pol_rev) ##2 (acc && reg_rd) |=> reg_rdata[14])
        else $error("polarity flag lost");
    a_jab_off: assert property (
        (ctrl_q[5] && clk_en)[*2] |=> !tx_jabber) else $error("jabber not off");
endmodule
bind tbops_reg tbops_reg_sva u_sva (.ref_clk, .rstn, .clk_en, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_en, .rx_pol_rev,
    .rx_link_lost, .full_duplex, .repeater, .col, .tx_jabber, .pol_correct,
    .link_ok);
`default_nettype wire

// ==== test/tbops_sta.sv ====
`default_nettype none
module tbops_sta (
    input wire logic ref_clk, // clock
    output logic [4:0] reg_addr, // address
    output logic reg_wr = 1'b0, // write strobe
    output logic reg_rd = 1'b0, // read strobe
    output tbops_pkg::tbops_word_t reg_wdata, // write data
    input wire tbops_pkg::tbops_word_t reg_rdata // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    import tbops_pkg::*;
    initial reg_addr = 5'h12;
    initial reg_wdata = 16'h0000;
    task automatic wr(input logic [5:0] v);
        @(negedge ref_clk);
        reg_wdata <= {10'h000, v[5], 1'b1, v[3:0]};
        reg_wr <= 1'b1;
        @(negedge ref_clk);
        reg_wr <= 1'b0;
        // idle data is inverted so a stale word is never taken by accident
        reg_wdata <= ~reg_wdata;
    endtask
    task automatic rd(input logic [4:0] a, output tbops_word_t d);
        @(negedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= 5'h12;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_tenbase_t_ops_register.sv ====
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_tenbase_t_ops_register;
    timeunit 1ns;
    timeprecision 1ps;
    import tbops_pkg::*;
    localparam int unsigned JL = 20;
    localparam int unsigned SL = 4;
    logic ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, tx_en = 1'b0;
    logic rx_active = 1'b0, rx_pol_rev = 1'b0, rx_valid_data = 1'b0;
    logic rx_idle = 1'b0, rx_link_lost = 1'b0, full_duplex = 1'b0;
    logic repeater = 1'b0, reg_wr, reg_rd, col, tx_jabber, pol_correct;
    logic link_ok;
    logic [4:0] reg_addr;
    tbops_word_t reg_wdata, reg_rdata, d, p;
    int bad_count = 0, check_count = 0, n;
    logic [5:0] rw [6] = '{6'h10, 6'h30, 6'h18, 6'h14, 6'h12, 6'h3F};
    logic rp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic ep [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    tbops_reg #(.JAB_LIMIT(JL), .SQE_LEN(SL)) dut_u (.ref_clk, .rstn,
        .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_en,
        .rx_active, .rx_pol_rev, .rx_valid_data, .rx_idle, .rx_link_lost,
        .full_duplex, .repeater, .col, .tx_jabber, .pol_correct, .link_ok);
    tbops_sta sta_u (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata);
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic sqe(input int e);
        @(negedge ref_clk) tx_en <= 1'b1;
        @(negedge ref_clk) tx_en <= 1'b0;
        n = 0;
        repeat (SL + 4) @(negedge ref_clk) n += (col === 1'b1);
        `CHK(n, e)
    endtask
    task automatic lk(input logic l, v, i, e);
        @(negedge ref_clk);
        rx_link_lost <= l;
        rx_valid_data <= v;
        rx_idle <= i;
        repeat (4) @(negedge ref_clk);
        `CHK(link_ok, e)
    endtask
    initial begin
        repeat (4000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        rstn <= 1'b1;
        sta_u.rd(5'h12, d);
        `CHK(d, 16'h0010)
        for (int i = 0; i < 6; i++) begin
            sta_u.wr(rw[i]);
            rx_pol_rev <= rp[i];
            sta_u.rd(5'h12, d);
            sta_u.rd(5'h12, d);
            `CHK(d, {1'b0, rp[i], 8'h00, rw[i]})
            `CHK(pol_correct, ep[i])
        end
        $display("test table done");
        rx_pol_rev <= 1'b0;
        sta_u.rd(5'h12, p);
        sta_u.rd(5'h11, d);
        `CHK(d, p)
        sta_u.wr(6'h10);
        sqe(SL);
        full_duplex <= 1'b1;
        sqe(0);
        full_duplex <= 1'b0;
        repeater <= 1'b1;
        sqe(0);
        repeater <= 1'b0;
        sta_u.rd(5'h12, d);
        `CHK(d[2], 1'b0)
        sta_u.wr(6'h14);
        sqe(0);
        $display("test sqe done");
        sta_u.wr(6'h10);
        rx_active <= 1'b1;
        repeat (JL + 10) @(negedge ref_clk);
        `CHK(tx_jabber, 1'b0)
        rx_active <= 1'b0;
        sta_u.rd(5'h12, d);
        `CHK(d[15], 1'b1)
        sta_u.rd(5'h12, d);
        `CHK(d[15], 1'b0)
        tx_en <= 1'b1;
        repeat (JL + 10) @(negedge ref_clk);
        `CHK(tx_jabber, 1'b1)
        sta_u.wr(6'h30);
        repeat (3) @(negedge ref_clk);
        `CHK(tx_jabber, 1'b0)
        tx_en <= 1'b0;
        $display("test jabber done");
        sta_u.wr(6'h10);
        lk(1, 0, 0, 0);
        lk(0, 1, 0, 1);
        sta_u.wr(6'h11);
        lk(1, 0, 0, 0);
        lk(0, 1, 0, 0);
        lk(0, 0, 1, 1);
        sta_u.wr(6'h12);
        lk(1, 0, 0, 1);
        $display("test link done");
        sta_u.rd(5'h12, p);
        clk_en <= 1'b0;
        sta_u.wr(6'h18);
        sta_u.rd(5'h12, d);
        `CHK(d, p)
        clk_en <= 1'b1;
        sta_u.rd(5'h12, d);
        `CHK(d, 16'h0012)
        $display("test freeze done");
        rstn <= 1'b0;
        repeat (2) @(negedge ref_clk);
        rstn <= 1'b1;
        sta_u.rd(5'h12, d);
        `CHK(d, 16'h0010)
        `CHK(link_ok, 1'b0)
        $display("test reset done");
        conclude();
    end
endmodule
`default_nettype wire
